// File: hdl/hfa_defines.vh
`ifndef HFA_DEFINES_VH
`define HFA_DEFINES_VH

// operation codes on op_in
`define HFA_OP_ADD     2'h0
`define HFA_OP_CMP     2'h1
`define HFA_OP_DIV     2'h2
`define HFA_OP_FLT     2'h3

// 64-bit register image, sign held in the top bit
`define HFA_SIGN_POS   63
`define HFA_EXP_HI     62
`define HFA_EXP_LO     56
`define HFA_FRAC_HI    55
`define HFA_FRAC_LO    0

// condition register bit positions
`define HFA_CC_EXC     0
`define HFA_CC_POS     1
`define HFA_CC_NEG     2
`define HFA_CC_ZERO    3
`define HFA_CC_CMP_RES 4
`define HFA_CC_CMP_HI  5
`define HFA_CC_CMP_LO  6
`define HFA_CC_CMP_EQ  7

// exponent figures, excess-64 codes held in 10-bit signed form
`define HFA_EXP_BIAS   10'h040
`define HFA_EXP_MAX    10'h07f
`define HFA_DIV_WRAP   10'h07f
`define HFA_FLT_EXP    10'h044

// divide takes 60 quotient bits, counter runs 59 down to 0
`define HFA_DIV_STEPS  6'h3b

`endif

// File: hdl/hfa_fpr_file.v
`timescale 1ns/1ps
// eight float registers, each four 16-bit words of one state's file
module hfa_fpr_file (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire [2:0]  ex_state_in,
  input  wire        ex_we_in,
  input  wire [63:0] ex_wdata_in,
  output wire [63:0] ex_rdata_out,
  input  wire        mc_we_in,
  input  wire [2:0]  mc_state_in,
  input  wire [1:0]  mc_word_in,
  input  wire [15:0] mc_wdata_in,
  output reg  [15:0] mc_rdata_out
);

  reg [15:0] word_q [0:31];

  // execution view: four consecutive words, most significant first
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1)
    begin : g_rd
      localparam [1:0] WK = k;
      assign ex_rdata_out[63-16*k -: 16] = word_q[{ex_state_in, WK}]; // [RULE_03]
    end
  endgenerate

  // storage update; execution write has priority over microcode
  always @(posedge clk_in)
  begin
    if (ex_we_in)
    begin
      word_q[{ex_state_in, 2'h0}] <= ex_wdata_in[63:48]; // [RULE_04]
      word_q[{ex_state_in, 2'h1}] <= ex_wdata_in[47:32];
      word_q[{ex_state_in, 2'h2}] <= ex_wdata_in[31:16];
      word_q[{ex_state_in, 2'h3}] <= ex_wdata_in[15:0];
    end
    else if (mc_we_in)
    begin
      word_q[{mc_state_in, mc_word_in}] <= mc_wdata_in; // [RULE_05]
    end
  end

  // microcode read port, registered
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      mc_rdata_out <= 16'h0000;
    else
      mc_rdata_out <= word_q[{mc_state_in, mc_word_in}]; // [RULE_05]
  end

endmodule

// File: hdl/hfa_unit.v
// Functional notes
// [RULE_01] exception sets bit 0 plus 3 overflow, 2 underflow, 3 zero divisor
// [RULE_02] non-compare result above zero sets bit 1 alone
// [RULE_03] one float register per state, four words each, eight total
// [RULE_04] sign bit 0, exponent bits 1-7, fraction digits follow in words
// [RULE_05] operations use current state's register; only microcode reaches it directly
// [RULE_06] add aligns smaller exponent one hex digit per shift
// [RULE_07] add forms 15-digit sum; carry shifts right, exponent above +63 overflows
// [RULE_08] add normalizes, underflow below -64, truncates to 14 digits
// [RULE_09] add sets bit 1 positive, 2 negative, 3 zero
// [RULE_10] add underflow bits 0,2; overflow bits 0,3; exponent off by 128
// [RULE_11] add or divide exception branches to exception pointer address
// [RULE_12] compare leaves both operands; zero fractions compare equal
// [RULE_13] compare clears 0,4; sets 3,7 equal, 2,6 memory less, 1,5 greater
// [RULE_14] divide exponent is difference plus 64, signed fractions, remainder dropped
// [RULE_15] divide overflow above +63, underflow below -64
// [RULE_16] zero divisor: no divide, register kept, bits 0 and 3
// [RULE_17] divide underflow bits 0,2, overflow bits 0,3, exponent off by 127
// [RULE_18] divide sets bit 1 positive, 2 negative, 3 zero
// [RULE_19] convert 16-bit signed integer, register or indirect word, normalized
// [RULE_20] convert sets bit 1 positive, 2 negative, 3 zero
// [RULE_21] non-compare zero result sets bit 3, negative sets bit 2
// [RULE_22] zero fraction result forces whole value to zero
// [RULE_23] exponent is excess-64 power of sixteen
`timescale 1ns/1ps
`include "hfa_defines.vh"
module hfa_unit (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire        start_in,
  input  wire [1:0]  op_in,
  input  wire [2:0]  cpu_state_in,
  input  wire [63:0] mem_operand_in,
  input  wire [15:0] int_reg_in,
  input  wire [15:0] int_mem_in,
  input  wire        int_indirect_in,
  input  wire [15:0] exc_pointer_in,
  input  wire        mc_we_in,
  input  wire [2:0]  mc_state_in,
  input  wire [1:0]  mc_word_in,
  input  wire [15:0] mc_wdata_in,
  output reg         busy_out,
  output reg         done_out,
  output reg  [7:0]  cond_out,
  output reg         exc_branch_out,
  output reg  [15:0] exc_target_out,
  output wire [15:0] mc_rdata_out
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_ALIGN = 3'h1;
  localparam [2:0] S_SUM   = 3'h2;
  localparam [2:0] S_DIV   = 3'h3;
  localparam [2:0] S_NORM  = 3'h4;
  localparam [2:0] S_FIN   = 3'h5;

  reg [2:0]  st_q;
  reg [1:0]  op_q;
  reg [2:0]  cs_q;
  reg [15:0] ptr_q;
  reg        sign_q;
  reg        sb_q;
  reg [9:0]  ea_q;
  reg [9:0]  eb_q;
  reg [63:0] w_q;
  reg [63:0] bw_q;
  reg [58:0] dv_q;
  reg [5:0]  cnt_q;

  wire [63:0] fpr_rd;
  wire        fpr_we;
  wire [63:0] fpr_wd;

  // condition code for a signed result
  function [7:0] hfa_sign_cond;
    input zero;
    input neg;
    begin
      hfa_sign_cond = 8'h00;
      if (zero)
        hfa_sign_cond[`HFA_CC_ZERO] = 1'b1; // [RULE_21]
      else if (neg)
        hfa_sign_cond[`HFA_CC_NEG] = 1'b1; // [RULE_21]
      else
        hfa_sign_cond[`HFA_CC_POS] = 1'b1; // [RULE_02]
    end
  endfunction

  // condition code for a compare outcome
  function [7:0] hfa_cmp_cond;
    input eq;
    input mem_gt;
    begin
      hfa_cmp_cond = 8'h00;
      if (eq)
      begin
        hfa_cmp_cond[`HFA_CC_ZERO]   = 1'b1;
        hfa_cmp_cond[`HFA_CC_CMP_EQ] = 1'b1;
      end
      else if (mem_gt)
      begin
        hfa_cmp_cond[`HFA_CC_POS]    = 1'b1;
        hfa_cmp_cond[`HFA_CC_CMP_HI] = 1'b1;
      end
      else
      begin
        hfa_cmp_cond[`HFA_CC_NEG]    = 1'b1;
        hfa_cmp_cond[`HFA_CC_CMP_LO] = 1'b1;
      end
    end
  endfunction

  // field split of the current register and the memory operand
  wire        fa_sign = fpr_rd[`HFA_SIGN_POS];
  wire [9:0]  fa_exp  = {3'h0, fpr_rd[`HFA_EXP_HI:`HFA_EXP_LO]}; // [RULE_23]
  wire [55:0] fa_frac = fpr_rd[`HFA_FRAC_HI:`HFA_FRAC_LO];
  wire        mb_sign = mem_operand_in[`HFA_SIGN_POS];
  wire [9:0]  mb_exp  = {3'h0, mem_operand_in[`HFA_EXP_HI:`HFA_EXP_LO]};
  wire [55:0] mb_frac = mem_operand_in[`HFA_FRAC_HI:`HFA_FRAC_LO];

  // integer source for conversion, direct or indirect
  wire [15:0] int_val = int_indirect_in ? int_mem_in : int_reg_in; // [RULE_19]
  wire [15:0] int_mag = int_val[15] ? (16'h0000 - int_val) : int_val;

  // compare: zero fractions rank as plain zero whatever sign and exponent
  wire        za     = (fa_frac == 56'h0);
  wire        zb     = (mb_frac == 56'h0);
  wire        neg_a  = fa_sign & ~za;
  wire        neg_b  = mb_sign & ~zb;
  wire [62:0] key_a  = za ? 63'h0 : {fa_exp[6:0], fa_frac};
  wire [62:0] key_b  = zb ? 63'h0 : {mb_exp[6:0], mb_frac};
  wire        cmp_eq = (key_a == key_b) && (neg_a == neg_b); // [RULE_12]
  wire        cmp_gt = (neg_a != neg_b) ? neg_a :
                       (neg_a ? (key_b < key_a) : (key_b > key_a));

  // one restoring divide step against divisor scaled by eight
  wire        div_ge  = (bw_q[59:0] >= {1'b0, dv_q});
  wire [59:0] div_rem = div_ge ? (bw_q[59:0] - {1'b0, dv_q}) : bw_q[59:0];

  // final result checks on the normalized working value
  wire        res_zero = (w_q[59:4] == 56'h0);
  wire        res_of   = ($signed(ea_q) > $signed(`HFA_EXP_MAX));
  wire        res_uf   = ea_q[9];
  wire        is_div   = (op_q == `HFA_OP_DIV);
  wire        res_exc  = ~res_zero & (res_of | res_uf) & (op_q != `HFA_OP_FLT);
  wire [9:0]  div_fix  = res_of ? (ea_q - `HFA_DIV_WRAP) : (ea_q + `HFA_DIV_WRAP);
  wire [6:0]  res_exp  = (is_div && res_exc) ? div_fix[6:0] : ea_q[6:0];
  reg  [7:0]  res_cond;

  // result condition bits, exception codes take over the sign codes
  always @*
  begin
    res_cond = hfa_sign_cond(res_zero, sign_q); // [RULE_09] [RULE_18] [RULE_20]
    if (res_exc)
    begin
      res_cond = 8'h00;
      res_cond[`HFA_CC_EXC] = 1'b1; // [RULE_01]
      if (res_of)
        res_cond[`HFA_CC_ZERO] = 1'b1; // [RULE_10] [RULE_17]
      else
        res_cond[`HFA_CC_NEG] = 1'b1; // [RULE_10] [RULE_17]
    end
  end

  // result write back; a zero fraction yields a true zero
  assign fpr_we = (st_q == S_FIN) && (op_q != `HFA_OP_CMP);
  assign fpr_wd = res_zero ? 64'h0 : {sign_q, res_exp, w_q[59:4]}; // [RULE_22] [RULE_08]

  hfa_fpr_file u_fpr (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .ex_state_in  (busy_out ? cs_q : cpu_state_in), // [RULE_05]
    .ex_we_in     (fpr_we),
    .ex_wdata_in  (fpr_wd),
    .ex_rdata_out (fpr_rd),
    .mc_we_in     (mc_we_in),
    .mc_state_in  (mc_state_in),
    .mc_word_in   (mc_word_in),
    .mc_wdata_in  (mc_wdata_in),
    .mc_rdata_out (mc_rdata_out)
  );

  // operation sequencer
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_q           <= S_IDLE;
      op_q           <= `HFA_OP_ADD;
      cs_q           <= 3'h0;
      ptr_q          <= 16'h0000;
      sign_q         <= 1'b0;
      sb_q           <= 1'b0;
      ea_q           <= 10'h000;
      eb_q           <= 10'h000;
      w_q            <= 64'h0;
      bw_q           <= 64'h0;
      dv_q           <= 59'h0;
      cnt_q          <= 6'h00;
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
      cond_out       <= 8'h00;
      exc_branch_out <= 1'b0;
      exc_target_out <= 16'h0000;
    end
    else
    begin
      done_out       <= 1'b0;
      exc_branch_out <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          if (start_in)
          begin
            op_q  <= op_in;
            cs_q  <= cpu_state_in;
            ptr_q <= exc_pointer_in;
            case (op_in)
              `HFA_OP_ADD:
              begin
                sign_q   <= fa_sign;
                sb_q     <= mb_sign;
                ea_q     <= fa_exp;
                eb_q     <= mb_exp;
                w_q      <= {4'h0, fa_frac, 4'h0}; // [RULE_07]
                bw_q     <= {4'h0, mb_frac, 4'h0};
                busy_out <= 1'b1;
                st_q     <= S_ALIGN;
              end
              `HFA_OP_CMP:
              begin
                cond_out <= hfa_cmp_cond(cmp_eq, cmp_gt); // [RULE_13]
                done_out <= 1'b1;
              end
              `HFA_OP_DIV:
              begin
                if (zb)
                begin
                  cond_out       <= 8'h00 | (8'h01 << `HFA_CC_EXC) | (8'h01 << `HFA_CC_ZERO); // [RULE_16]
                  exc_branch_out <= 1'b1; // [RULE_11]
                  exc_target_out <= exc_pointer_in;
                  done_out       <= 1'b1;
                end
                else
                begin
                  sign_q   <= fa_sign ^ mb_sign; // [RULE_14]
                  ea_q     <= fa_exp - mb_exp + `HFA_EXP_BIAS; // [RULE_14]
                  w_q      <= 64'h0;
                  bw_q     <= {8'h00, fa_frac};
                  dv_q     <= {mb_frac, 3'h0};
                  cnt_q    <= `HFA_DIV_STEPS;
                  busy_out <= 1'b1;
                  st_q     <= S_DIV;
                end
              end
              default:
              begin
                sign_q   <= int_val[15]; // [RULE_19]
                ea_q     <= `HFA_FLT_EXP;
                w_q      <= {4'h0, int_mag, 44'h0};
                busy_out <= 1'b1;
                st_q     <= S_NORM;
              end
            endcase
          end
        end
        S_ALIGN:
        begin
          // one hex digit per cycle on the smaller exponent
          if (ea_q < eb_q)
          begin
            w_q  <= {4'h0, w_q[63:4]}; // [RULE_06]
            ea_q <= ea_q + 10'h001;
          end
          else if (eb_q < ea_q)
          begin
            bw_q <= {4'h0, bw_q[63:4]}; // [RULE_06]
            eb_q <= eb_q + 10'h001;
          end
          else
            st_q <= S_SUM;
        end
        S_SUM:
        begin
          // signed-magnitude add of the aligned fractions
          if (sign_q == sb_q)
            w_q <= w_q + bw_q; // [RULE_07]
          else if (w_q >= bw_q)
            w_q <= w_q - bw_q;
          else
          begin
            w_q    <= bw_q - w_q;
            sign_q <= sb_q;
          end
          st_q <= S_NORM;
        end
        S_DIV:
        begin
          // quotient bits enter the 60-bit field, remainder is dropped
          bw_q  <= {4'h0, div_rem[58:0], 1'b0};
          w_q   <= {w_q[62:4], div_ge, 4'h0}; // [RULE_14]
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h00)
            st_q <= S_NORM;
        end
        S_NORM:
        begin
          // carry digit shifts right, leading zero digits shift left
          if (w_q[63:60] != 4'h0)
          begin
            w_q  <= {4'h0, w_q[63:4]}; // [RULE_07]
            ea_q <= ea_q + 10'h001;
          end
          else if ((w_q[59:56] == 4'h0) && (w_q[59:0] != 60'h0))
          begin
            w_q  <= {w_q[59:0], 4'h0}; // [RULE_08]
            ea_q <= ea_q - 10'h001;
          end
          else
            st_q <= S_FIN;
        end
        S_FIN:
        begin
          cond_out       <= res_cond; // [RULE_15]
          exc_branch_out <= res_exc; // [RULE_11]
          exc_target_out <= ptr_q;
          done_out       <= 1'b1;
          busy_out       <= 1'b0;
          st_q           <= S_IDLE;
        end
        default:
        begin
          busy_out <= 1'b0;
          st_q     <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// File: test/hfa_assertions.sv
`timescale 1ns/1ps
`include "hfa_defines.vh"
module hfa_assertions (
  input wire        clk_in,
  input wire        sys_rst_in,
  input wire        start_in,
  input wire [1:0]  op_in,
  input wire [15:0] exc_pointer_in,
  input wire        mc_we_in,
  input wire [2:0]  mc_state_in,
  input wire [1:0]  mc_word_in,
  input wire [15:0] mc_wdata_in,
  input wire        busy_out,
  input wire        done_out,
  input wire [7:0]  cond_out,
  input wire        exc_branch_out,
  input wire [15:0] exc_target_out,
  input wire [15:0] mc_rdata_out
);
  reg  [1:0]  op_q;
  reg  [15:0] ptr_q;
  wire        take = start_in && !busy_out;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // operation and pointer of the accepted request
  always @(posedge clk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      op_q  <= 2'h0;
      ptr_q <= 16'h0000;
    end
    else if (take)
    begin
      op_q  <= op_in;
      ptr_q <= exc_pointer_in;
    end
  property p_done_pulse;
    done_out && !start_in |=> !done_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held too long");
  property p_cmp_fast;
    take && op_in == `HFA_OP_CMP |=> done_out && !busy_out;
  endproperty
  a_cmp_fast: assert property (p_cmp_fast) else $error("compare not done next cycle");
  // worst add: 127 align shifts, sum, 14 normalize shifts, finish
  property p_op_ends;
    take && op_in != `HFA_OP_CMP |-> ##[1:150] done_out;
  endproperty
  a_op_ends: assert property (p_op_ends) else $error("operation never completed");
  property p_exc_jump;
    exc_branch_out |-> done_out && op_q != `HFA_OP_CMP && exc_target_out == ptr_q;
  endproperty
  a_exc_jump: assert property (p_exc_jump) else $error("bad exception branch");
  property p_exc_flag;
    done_out |-> cond_out[0] == exc_branch_out;
  endproperty
  a_exc_flag: assert property (p_exc_flag) else $error("exception flag without branch");
  property p_exc_code;
    exc_branch_out |-> cond_out[0] && $onehot(cond_out[3:1]);
  endproperty
  a_exc_code: assert property (p_exc_code) else $error("bad exception code");
  property p_cmp_code;
    done_out && op_q == `HFA_OP_CMP |-> !cond_out[0] && !cond_out[4] && cond_out[7:5] == cond_out[3:1]
      && $onehot(cond_out[3:1]);
  endproperty
  a_cmp_code: assert property (p_cmp_code) else $error("bad compare code");
  property p_sign_code;
    done_out && op_q != `HFA_OP_CMP && !cond_out[0] |-> $onehot(cond_out[3:1]);
  endproperty
  a_sign_code: assert property (p_sign_code) else $error("bad result code");
  property p_cvt_clean;
    done_out && op_q == `HFA_OP_FLT |-> !cond_out[0];
  endproperty
  a_cvt_clean: assert property (p_cvt_clean) else $error("convert raised exception");
  property p_cc_hold;
    !$stable(cond_out) |-> done_out;
  endproperty
  a_cc_hold: assert property (p_cc_hold) else $error("condition changed outside done");
  property p_mc_read;
    mc_we_in && !busy_out ##1 (!mc_we_in && !busy_out && $stable(mc_state_in) && $stable(mc_word_in))
      |=> mc_rdata_out == $past(mc_wdata_in, 2);
  endproperty
  a_mc_read: assert property (p_mc_read) else $error("microcode readback wrong");
  c_cmp: cover property (take && op_in == `HFA_OP_CMP);
  c_exc: cover property (exc_branch_out);
  c_cvt: cover property (done_out && op_q == `HFA_OP_FLT);
endmodule
bind hfa_unit hfa_assertions u_hfa_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in), .op_in(op_in),
  .exc_pointer_in(exc_pointer_in), .mc_we_in(mc_we_in), .mc_state_in(mc_state_in),
  .mc_word_in(mc_word_in), .mc_wdata_in(mc_wdata_in), .busy_out(busy_out), .done_out(done_out),
  .cond_out(cond_out), .exc_branch_out(exc_branch_out), .exc_target_out(exc_target_out),
  .mc_rdata_out(mc_rdata_out));

// File: test/hfa_store_model.sv
`timescale 1ns/1ps
// four-word memory field feeding the operand
module hfa_store_model (
  input  wire        clk_in,
  input  wire        load_in,
  input  wire [63:0] data_in,
  output wire [63:0] operand_out
);
  reg [15:0] word_q [0:3];
  integer    i;
  // keep the field as four words
  always @(posedge clk_in)
    if (load_in)
      for (i = 0; i < 4; i = i + 1)
        word_q[i] <= data_in[63-16*i -: 16];
  // most significant word first
  assign operand_out = {word_q[0], word_q[1], word_q[2], word_q[3]};
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  localparam [63:0] one_f = 64'h4110000000000000;
  localparam [63:0] two_f = 64'h4120000000000000;
  reg         clk_in = 1'b0;
  reg         sys_rst_in = 1'b1;
  reg         start_in = 1'b0;
  reg  [1:0]  op_in = 2'h0;
  reg  [2:0]  cpu_state_in = 3'h0;
  reg  [15:0] int_reg_in = 16'h0000;
  reg  [15:0] int_mem_in = 16'h0000;
  reg         int_indirect_in = 1'b0;
  reg  [15:0] exc_pointer_in = 16'h0000;
  reg         mc_we_in = 1'b0;
  reg  [2:0]  mc_state_in = 3'h0;
  reg  [1:0]  mc_word_in = 2'h0;
  reg  [15:0] mc_wdata_in = 16'h0000;
  reg  [63:0] st_data = 64'h0;
  reg         st_load = 1'b0;
  reg  [63:0] rd_v;
  wire [63:0] mem_operand_in;
  wire        busy_out;
  wire        done_out;
  wire        exc_branch_out;
  wire [7:0]  cond_out;
  wire [15:0] exc_target_out;
  wire [15:0] mc_rdata_out;
  integer     error_cnt = 0;
  integer     total_checks = 0;
  integer     cyc = 0;
  hfa_store_model u_store (.clk_in(clk_in), .load_in(st_load), .data_in(st_data), .operand_out(mem_operand_in));
  hfa_unit dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in), .op_in(op_in),
    .cpu_state_in(cpu_state_in), .mem_operand_in(mem_operand_in), .int_reg_in(int_reg_in),
    .int_mem_in(int_mem_in), .int_indirect_in(int_indirect_in), .exc_pointer_in(exc_pointer_in),
    .mc_we_in(mc_we_in), .mc_state_in(mc_state_in), .mc_word_in(mc_word_in), .mc_wdata_in(mc_wdata_in),
    .busy_out(busy_out), .done_out(done_out), .cond_out(cond_out), .exc_branch_out(exc_branch_out),
    .exc_target_out(exc_target_out), .mc_rdata_out(mc_rdata_out));
  // clock and hang guard
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  task complete_run;
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task tick;
    @(posedge clk_in);
    #1;
  endtask
  task chk_val(input [63:0] e, input [63:0] g);
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task chk_cc(input [7:0] e, input [7:0] g);
    chk_val({56'h0, e}, {56'h0, g});
  endtask
  // microcode access, one word per cycle
  task fpr_wr(input [2:0] s, input [63:0] v);
    integer i;
    for (i = 0; i < 4; i = i + 1)
    begin
      mc_we_in = 1'b1;
      mc_state_in = s;
      mc_word_in = i[1:0];
      mc_wdata_in = v[63-16*i -: 16];
      tick;
    end
    // idle cycle so a following write never re-raises the strobe at once
    mc_we_in = 1'b0;
    tick;
  endtask
  task fpr_rd(input [2:0] s, output [63:0] v);
    integer i;
    for (i = 0; i < 4; i = i + 1)
    begin
      mc_state_in = s;
      mc_word_in = i[1:0];
      tick;
      v[63-16*i -: 16] = mc_rdata_out;
    end
  endtask
  // start one operation and wait for done
  task go(input [1:0] op, input [2:0] s, input [63:0] r, input [7:0] cc);
    integer n;
    op_in = op;
    cpu_state_in = s;
    exc_pointer_in = {13'h0ace, s};
    start_in = 1'b1;
    tick;
    start_in = 1'b0;
    for (n = 0; n < 200 && done_out !== 1'b1; n = n + 1)
      tick;
    // a missing done is a mismatch and ends the run
    if (done_out !== 1'b1)
    begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
    chk_val(64'h0, {63'h0, busy_out});
    chk_cc(cc, cond_out);
    chk_val({63'h0, cc[0]}, {63'h0, exc_branch_out});
    if (cc[0])
      chk_val({48'h0, 13'h0ace, s}, {48'h0, exc_target_out});
    tick;
    fpr_rd(s, rd_v);
    chk_val(r, rd_v);
  endtask
  task op_case(input [1:0] op, input [2:0] s, input [63:0] f, input [63:0] m, input [63:0] r, input [7:0] cc);
    fpr_wr(s, f);
    st_data = m;
    st_load = 1'b1;
    tick;
    st_load = 1'b0;
    go(op, s, r, cc);
  endtask
  // the unselected source carries a decoy
  task cvt_case(input [2:0] s, input [15:0] iv, input ind, input [63:0] r, input [7:0] cc);
    fpr_wr(s, 64'h1234567890abcdef);
    int_indirect_in = ind;
    int_reg_in = ind ? ~iv : iv;
    int_mem_in = ind ? iv : ~iv;
    go(2'h3, s, r, cc);
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    tick;
    fpr_wr(3'h7, 64'h5a5a0f0fa5a5f0f0);
    op_case(2'h0, 3'h1, one_f, two_f, 64'h4130000000000000, 8'h02);
    op_case(2'h0, 3'h2, 64'h4210000000000000, one_f, 64'h4211000000000000, 8'h02);
    op_case(2'h0, 3'h3, 64'h41f0000000000000, 64'h41f0000000000000, 64'h421e000000000000, 8'h02);
    op_case(2'h0, 3'h4, one_f, 64'hc130000000000000, 64'hc120000000000000, 8'h04);
    op_case(2'h0, 3'h5, one_f, 64'hc110000000000000, 64'h0, 8'h08);
    op_case(2'h0, 3'h6, one_f, 64'h400000000000000f, one_f, 8'h02);
    op_case(2'h0, 3'h0, 64'h7ff0000000000000, 64'h7ff0000000000000, 64'h001e000000000000, 8'h09);
    op_case(2'h0, 3'h1, 64'h0011000000000000, 64'h8010000000000000, 64'h7f10000000000000, 8'h05);
    op_case(2'h1, 3'h2, two_f, two_f, two_f, 8'h88);
    op_case(2'h1, 3'h3, two_f, one_f, two_f, 8'h44);
    op_case(2'h1, 3'h4, two_f, 64'h4210000000000000, two_f, 8'h22);
    op_case(2'h1, 3'h5, 64'hc120000000000000, 64'hc130000000000000, 64'hc120000000000000, 8'h44);
    op_case(2'h1, 3'h6, 64'h4100000000000000, 64'h8500000000000000, 64'h4100000000000000, 8'h88);
    op_case(2'h2, 3'h0, two_f, one_f, two_f, 8'h02);
    op_case(2'h2, 3'h1, two_f, 64'hc110000000000000, 64'hc120000000000000, 8'h04);
    op_case(2'h2, 3'h2, two_f, 64'h4100000000000000, two_f, 8'h09);
    op_case(2'h2, 3'h3, 64'h7f20000000000000, 64'h0040000000000000, 64'h4080000000000000, 8'h09);
    op_case(2'h2, 3'h4, 64'h0020000000000000, 64'h7f40000000000000, 64'h4080000000000000, 8'h05);
    cvt_case(3'h5, 16'h0001, 1'b0, one_f, 8'h02);
    cvt_case(3'h6, 16'hff00, 1'b0, 64'hc310000000000000, 8'h04);
    cvt_case(3'h0, 16'h0000, 1'b0, 64'h0, 8'h08);
    cvt_case(3'h1, 16'h8000, 1'b1, 64'hc480000000000000, 8'h04);
    fpr_rd(3'h7, rd_v);
    chk_val(64'h5a5a0f0fa5a5f0f0, rd_v);
    complete_run;
  end
endmodule
